//--- rtl/qdc_pkg.sv
package qdc_pkg;

	// Bank layout: eight converters, one word each
	localparam int N_CONV = 8;
	localparam logic [7:0] OFS_SETUP = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h20;
	localparam logic [7:0] OFS_STAT = 8'h40;
	localparam int BANK_LSB = 5;
	localparam int IDX_LSB = 2;

	// Converter setup word
	localparam logic [31:0] SETUP_MASK = 32'h000f_efff;
	localparam logic [31:0] SETUP_RST = 32'h0000_4000;
	localparam int SETUP_W = 20;
	localparam int CLEAR_VALUE_SELECT_BIT = 13;
	localparam int PWR_LSB = 16;
	localparam int RANGE_W = 3;

	// Converter control word
	localparam logic [31:0] CTRL_MASK = 32'h0000_01bf;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int STAT_REQ_BIT = 9;
	localparam int GLOBAL_BIT = 8;
	localparam int ASR_BIT = 7;
	localparam int SEQ_IRQ_BIT = 5;
	localparam int ALERT_IRQ_BIT = 4;
	localparam int LOAD_IRQ_BIT = 3;
	localparam int MODE_LSB = 0;

	// Status word
	localparam int STAT_W = 10;
	localparam int STAT_VALID_BIT = 10;
	localparam logic [STAT_W-1:0] STAT_RST = 10'h000;

	// Delay of the timer-mode status read after an output update
	localparam int CLK_PERIOD_NS = 4;
	localparam int STAT_DELAY_NS = 10000;
	localparam int STAT_DELAY_CYC = STAT_DELAY_NS / CLK_PERIOD_NS;
	localparam int DLY_W = 12;
	localparam logic [DLY_W-1:0] DLY_ZERO = 12'h000;
	localparam logic [DLY_W-1:0] DLY_LOAD = DLY_W'(STAT_DELAY_CYC);

	typedef enum logic [2:0] {
		MODE_INSTANT = 3'h0,
		MODE_MANUAL = 3'h1,
		MODE_TIMER = 3'h3
	} qdc_mode_t;

	typedef enum logic [1:0] {
		CLR_ZERO = 2'h0,
		CLR_MID = 2'h1,
		CLR_NEG_FULL = 2'h2
	} qdc_clr_t;

	typedef enum logic {
		DISP_IDLE = 1'b0,
		DISP_WAIT = 1'b1
	} qdc_disp_t;

	typedef struct packed {
		logic cfg;
		logic [2:0] sel;
		logic [SETUP_W-1:0] setup;
	} qdc_xfer_t;

	typedef struct packed {
		logic global_load_enable;
		logic auto_status_read_enable;
		logic sequencer_irq_enable;
		logic alert_irq_enable;
		logic load_irq_enable;
		logic [2:0] mode;
	} qdc_ctrl_t;

	// Codes 3..5 are the bipolar spans
	function automatic logic range_bipolar(input logic [RANGE_W-1:0] code);
		range_bipolar = (code >= 3'h3) && (code <= 3'h5);
	endfunction

	function automatic logic [2:0] first_set(input logic [N_CONV-1:0] v);
		first_set = 3'h0;
		for (int i = N_CONV - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = 3'(i);
			end
		end
	endfunction

endpackage

//--- rtl/qdc_auto_stat.sv
`timescale 1ns/1ps
`default_nettype none
module qdc_auto_stat
	import qdc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic asr_en_in,
	input wire logic [2:0] mode_in,
	input wire logic tick_in,
	input wire logic update_in,
	output logic req_out
);

	logic [DLY_W-1:0] cnt_q;
	logic timed;

	assign timed = asr_en_in && (mode_in == MODE_TIMER);

	// One read per sequence, a fixed delay after the output update
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !timed) begin
			cnt_q <= DLY_ZERO;
		end else if (update_in) begin
			cnt_q <= DLY_LOAD;
		end else if (cnt_q != DLY_ZERO) begin
			cnt_q <= cnt_q - 12'h001;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			req_out <= 1'b0;
		end else begin
			req_out <= (timed && !update_in && cnt_q == 12'h001) ||
				(asr_en_in && tick_in && (mode_in == MODE_INSTANT || mode_in == MODE_MANUAL));
		end
	end

endmodule
`default_nettype wire

//--- rtl/qdc_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Eight control words, bank at 0x20
// - Reserved bits written zero, read zero
// - Four 3-bit range codes, reset zero
// - Range codes select unipolar/bipolar spans
// - Status request only in instant/manual modes
// - Request logs read, clears status valid
// - Read completion stores status, sets valid
// - Read may wait; request reads zero
// - Global load updates manual-mode converters together
// - Standalone manual converter updates alone
// - Auto status read paced by tick
// - Timer mode: one read 10us after update
// - Bit 5 gates sequencer interrupts
// - Bit 4 gates alert interrupts
// - Bit 3 gates load interrupt
// - Mode field bits 2:0 selects update mode
// - Setup write starts transfer unless busy
// - Power-up bits 16-19 enable channels
module qdc_ctrl_regs
	import qdc_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK_IN,
	input wire logic RST_N_IN,
	// Register port
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [31:0] REG_WDATA_IN,
	output logic [31:0] REG_RDATA_OUT,
	output logic REG_RVALID_OUT,
	// Converter transactions
	output var qdc_xfer_t XFER_OUT,
	output logic XFER_VALID_OUT,
	input wire logic XFER_DONE_IN,
	input wire logic [STAT_W-1:0] XFER_STATUS_IN,
	output logic [N_CONV-1:0] BUSY_OUT,
	// Update control
	input wire logic [N_CONV-1:0] CHAN_DONE_IN,
	input wire logic AUTO_TICK_IN,
	output logic [N_CONV-1:0] UPDATE_OUT,
	output var qdc_ctrl_t [N_CONV-1:0] CTRL_OUT,
	output logic [N_CONV-1:0][3:0][1:0] CLR_LVL_OUT,
	// Interrupt events
	input wire logic [N_CONV-1:0] SEQ_EVT_IN,
	input wire logic [N_CONV-1:0] ALERT_EVT_IN,
	output logic [N_CONV-1:0] SEQ_IRQ_OUT,
	output logic [N_CONV-1:0] ALERT_IRQ_OUT,
	output logic [N_CONV-1:0] LOAD_IRQ_OUT
);

	logic [N_CONV-1:0][31:0] setup_q;
	logic [N_CONV-1:0][31:0] ctrl_q;
	logic [N_CONV-1:0][STAT_W-1:0] stat_q;
	logic [N_CONV-1:0] valid_q;
	logic [N_CONV-1:0] busy_q;
	logic [N_CONV-1:0] cfg_pend_q;
	logic [N_CONV-1:0] stat_pend_q;
	logic [N_CONV-1:0] gl_done_q;
	logic [N_CONV-1:0] auto_req;
	logic [N_CONV-1:0] setup_wr;
	logic [N_CONV-1:0] ctrl_wr;
	logic [N_CONV-1:0] stat_req;
	logic [N_CONV-1:0] done_hit;
	logic [N_CONV-1:0] manual;
	logic [N_CONV-1:0] members;
	logic [N_CONV-1:0] update_d;
	logic [N_CONV-1:0] dispatch;
	logic gl_fire;
	qdc_disp_t disp_q;
	qdc_xfer_t xfer_q;
	logic [2:0] idx;
	logic [2:0] bank;

	assign idx = REG_ADDR_IN[IDX_LSB +: 3];
	assign bank = REG_ADDR_IN[BANK_LSB +: 3];

	generate
		for (genvar i = 0; i < N_CONV; i++) begin : g_conv
			logic [2:0] mode_i;
			assign mode_i = ctrl_q[i][MODE_LSB +: 3];
			assign setup_wr[i] = REG_WR_IN && bank == OFS_SETUP[BANK_LSB +: 3] && idx == 3'(i);
			assign ctrl_wr[i] = REG_WR_IN && bank == OFS_CTRL[BANK_LSB +: 3] && idx == 3'(i);
			assign stat_req[i] = ctrl_wr[i] && REG_WDATA_IN[STAT_REQ_BIT] &&
				(mode_i == MODE_INSTANT || mode_i == MODE_MANUAL);
			assign done_hit[i] = disp_q == DISP_WAIT && XFER_DONE_IN && xfer_q.sel == 3'(i);
			assign manual[i] = mode_i == MODE_MANUAL;
			assign members[i] = manual[i] && ctrl_q[i][GLOBAL_BIT];
			assign dispatch[i] = disp_q == DISP_IDLE &&
				(cfg_pend_q != '0 ? (first_set(cfg_pend_q) == 3'(i)) :
				(stat_pend_q != '0 && first_set(stat_pend_q) == 3'(i)));

			qdc_auto_stat u_auto (
				.clk_in(CLOCK_IN),
				.rst_n_in(RST_N_IN),
				.asr_en_in(ctrl_q[i][ASR_BIT]),
				.mode_in(mode_i),
				.tick_in(AUTO_TICK_IN),
				.update_in(update_d[i]),
				.req_out(auto_req[i])
			);

			// Setup and control storage; reserved bits are dropped
			always_ff @(posedge CLOCK_IN) begin
				if (!RST_N_IN) begin
					setup_q[i] <= SETUP_RST;
				end else if (setup_wr[i] && !busy_q[i]) begin
					setup_q[i] <= REG_WDATA_IN & SETUP_MASK;
				end
			end

			always_ff @(posedge CLOCK_IN) begin
				if (!RST_N_IN) begin
					ctrl_q[i] <= CTRL_RST;
				end else if (ctrl_wr[i]) begin
					ctrl_q[i] <= REG_WDATA_IN & CTRL_MASK;
				end
			end

			// Busy spans the whole setup transfer
			always_ff @(posedge CLOCK_IN) begin
				if (!RST_N_IN) begin
					busy_q[i] <= 1'b0;
				end else if (setup_wr[i] && !busy_q[i]) begin
					busy_q[i] <= 1'b1;
				end else if (done_hit[i] && xfer_q.cfg) begin
					busy_q[i] <= 1'b0;
				end
			end

			always_ff @(posedge CLOCK_IN) begin
				if (!RST_N_IN) begin
					cfg_pend_q[i] <= 1'b0;
				end else if (setup_wr[i] && !busy_q[i]) begin
					cfg_pend_q[i] <= 1'b1;
				end else if (dispatch[i]) begin
					cfg_pend_q[i] <= 1'b0;
				end
			end

			// Logged reads wait for the link; a new request beats the dispatch
			always_ff @(posedge CLOCK_IN) begin
				if (!RST_N_IN) begin
					stat_pend_q[i] <= 1'b0;
				end else if (stat_req[i] || auto_req[i]) begin
					stat_pend_q[i] <= 1'b1;
				end else if (dispatch[i] && cfg_pend_q == '0) begin
					stat_pend_q[i] <= 1'b0;
				end
			end

			always_ff @(posedge CLOCK_IN) begin
				if (!RST_N_IN) begin
					stat_q[i] <= STAT_RST;
				end else if (done_hit[i]) begin
					stat_q[i] <= XFER_STATUS_IN;
				end
			end

			// Completion sets valid even when a request clears it in the same cycle
			always_ff @(posedge CLOCK_IN) begin
				if (!RST_N_IN) begin
					valid_q[i] <= 1'b0;
				end else if (done_hit[i]) begin
					valid_q[i] <= 1'b1;
				end else if (stat_req[i]) begin
					valid_q[i] <= 1'b0;
				end
			end

			// Global-load members wait for the whole group
			always_ff @(posedge CLOCK_IN) begin
				if (!RST_N_IN) begin
					gl_done_q[i] <= 1'b0;
				end else if (gl_fire || !members[i]) begin
					gl_done_q[i] <= 1'b0;
				end else if (CHAN_DONE_IN[i]) begin
					gl_done_q[i] <= 1'b1;
				end
			end

			always_comb begin
				if (members[i]) begin
					update_d[i] = gl_fire;
				end else if (manual[i]) begin
					update_d[i] = CHAN_DONE_IN[i];
				end else begin
					update_d[i] = CHAN_DONE_IN[i] &&
						(mode_i == MODE_INSTANT || mode_i == MODE_TIMER);
				end
			end

			// Clear level per channel from range polarity and clear select
			for (genvar c = 0; c < 4; c++) begin : g_ch
				always_ff @(posedge CLOCK_IN) begin
					if (!RST_N_IN) begin
						CLR_LVL_OUT[i][c] <= CLR_ZERO;
					end else if (!setup_q[i][CLEAR_VALUE_SELECT_BIT]) begin
						CLR_LVL_OUT[i][c] <= CLR_ZERO;
					end else if (range_bipolar(setup_q[i][c*RANGE_W +: RANGE_W])) begin
						CLR_LVL_OUT[i][c] <= CLR_NEG_FULL;
					end else begin
						CLR_LVL_OUT[i][c] <= CLR_MID;
					end
				end
			end

			always_ff @(posedge CLOCK_IN) begin
				if (!RST_N_IN) begin
					CTRL_OUT[i] <= '0;
				end else begin
					CTRL_OUT[i].global_load_enable <= ctrl_q[i][GLOBAL_BIT];
					CTRL_OUT[i].auto_status_read_enable <= ctrl_q[i][ASR_BIT];
					CTRL_OUT[i].sequencer_irq_enable <= ctrl_q[i][SEQ_IRQ_BIT];
					CTRL_OUT[i].alert_irq_enable <= ctrl_q[i][ALERT_IRQ_BIT];
					CTRL_OUT[i].load_irq_enable <= ctrl_q[i][LOAD_IRQ_BIT];
					CTRL_OUT[i].mode <= mode_i;
				end
			end

			// Interrupt gating
			always_ff @(posedge CLOCK_IN) begin
				if (!RST_N_IN) begin
					SEQ_IRQ_OUT[i] <= 1'b0;
					ALERT_IRQ_OUT[i] <= 1'b0;
					LOAD_IRQ_OUT[i] <= 1'b0;
				end else begin
					SEQ_IRQ_OUT[i] <= SEQ_EVT_IN[i] && ctrl_q[i][SEQ_IRQ_BIT];
					ALERT_IRQ_OUT[i] <= ALERT_EVT_IN[i] && ctrl_q[i][ALERT_IRQ_BIT];
					LOAD_IRQ_OUT[i] <= update_d[i] && ctrl_q[i][LOAD_IRQ_BIT];
				end
			end
		end
	endgenerate

	assign gl_fire = members != '0 && ((gl_done_q | CHAN_DONE_IN) & members) == members;

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			UPDATE_OUT <= '0;
			BUSY_OUT <= '0;
		end else begin
			UPDATE_OUT <= update_d;
			BUSY_OUT <= busy_q;
		end
	end

	// One converter transaction at a time, setups ahead of status reads
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			disp_q <= DISP_IDLE;
			xfer_q <= '0;
		end else begin
			unique case (disp_q)
				DISP_IDLE: begin
					if (cfg_pend_q != '0) begin
						disp_q <= DISP_WAIT;
						xfer_q.cfg <= 1'b1;
						xfer_q.sel <= first_set(cfg_pend_q);
						xfer_q.setup <= setup_q[first_set(cfg_pend_q)][SETUP_W-1:0];
					end else if (stat_pend_q != '0) begin
						disp_q <= DISP_WAIT;
						xfer_q.cfg <= 1'b0;
						xfer_q.sel <= first_set(stat_pend_q);
					end
				end
				DISP_WAIT: begin
					if (XFER_DONE_IN) begin
						disp_q <= DISP_IDLE;
					end
				end
			endcase
		end
	end

	assign XFER_OUT = xfer_q;
	assign XFER_VALID_OUT = disp_q == DISP_WAIT;

	// Read data one cycle after the strobe; unmapped words read zero
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			REG_RDATA_OUT <= 32'h0000_0000;
			REG_RVALID_OUT <= 1'b0;
		end else begin
			REG_RVALID_OUT <= REG_RD_IN;
			if (REG_RD_IN) begin
				unique case (bank)
					OFS_SETUP[BANK_LSB +: 3]: REG_RDATA_OUT <= setup_q[idx];
					OFS_CTRL[BANK_LSB +: 3]: REG_RDATA_OUT <= ctrl_q[idx];
					OFS_STAT[BANK_LSB +: 3]: begin
						REG_RDATA_OUT <= {21'h000000, valid_q[idx], stat_q[idx]};
					end
					default: REG_RDATA_OUT <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

//--- tb/qdc_ctrl_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module qdc_chk
	import qdc_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic RST_N_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic REG_RD_IN,
	input wire logic [31:0] REG_RDATA_OUT,
	input wire logic REG_RVALID_OUT,
	input wire qdc_xfer_t XFER_OUT,
	input wire logic XFER_VALID_OUT,
	input wire logic XFER_DONE_IN,
	input wire logic [N_CONV-1:0] CHAN_DONE_IN,
	input wire logic [N_CONV-1:0] UPDATE_OUT,
	input wire qdc_ctrl_t [N_CONV-1:0] CTRL_OUT,
	input wire logic [N_CONV-1:0] SEQ_EVT_IN,
	input wire logic [N_CONV-1:0] ALERT_EVT_IN,
	input wire logic [N_CONV-1:0] SEQ_IRQ_OUT,
	input wire logic [N_CONV-1:0] ALERT_IRQ_OUT
);
	logic [N_CONV-1:0] seq_en, al_en, inst, resv, inst_hit;
	logic [2:0] bank;
	assign bank = REG_ADDR_IN[7:5];
	assign inst_hit = CHAN_DONE_IN & inst;
	always_comb begin
		for (int i = 0; i < N_CONV; i++) begin
			seq_en[i] = CTRL_OUT[i].sequencer_irq_enable;
			al_en[i] = CTRL_OUT[i].alert_irq_enable;
			inst[i] = CTRL_OUT[i].mode == 3'h0;
			resv[i] = CTRL_OUT[i].mode[2] || CTRL_OUT[i].mode == 3'h2;
		end
	end
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_N_IN);
	sequence s_xfer_wait;
		XFER_VALID_OUT && !XFER_DONE_IN;
	endsequence
	sequence s_xfer_held;
		XFER_VALID_OUT && $stable(XFER_OUT);
	endsequence
	a_rd_answer: assert property (REG_RD_IN |=> REG_RVALID_OUT)
		else $error("read not answered");
	a_ctrl_mask: assert property (REG_RVALID_OUT && $past(bank) == 3'h1
		|-> (REG_RDATA_OUT & ~32'h0000_01bf) == 32'h0) else $error("control bits leak");
	a_xfer_hold: assert property (s_xfer_wait |=> s_xfer_held)
		else $error("transfer dropped early");
	a_xfer_drop: assert property (XFER_VALID_OUT && XFER_DONE_IN |=> !XFER_VALID_OUT)
		else $error("transfer outlives done");
	a_seq_gate: assert property ((SEQ_IRQ_OUT & ~(seq_en & $past(SEQ_EVT_IN))) == 8'h0)
		else $error("sequencer irq ungated");
	a_alert_gate: assert property ((ALERT_IRQ_OUT & ~(al_en & $past(ALERT_EVT_IN))) == 8'h0)
		else $error("alert irq ungated");
	a_inst_update: assert property (|inst_hit |=> (UPDATE_OUT & $past(inst_hit)) == $past(inst_hit))
		else $error("instant update missing");
	a_resv_quiet: assert property ((UPDATE_OUT & resv) == 8'h0)
		else $error("update in reserved mode");
endmodule
bind qdc_ctrl_regs qdc_chk u_chk (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
	.REG_ADDR_IN(REG_ADDR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
	.REG_RVALID_OUT(REG_RVALID_OUT), .XFER_OUT(XFER_OUT), .XFER_VALID_OUT(XFER_VALID_OUT),
	.XFER_DONE_IN(XFER_DONE_IN), .CHAN_DONE_IN(CHAN_DONE_IN), .UPDATE_OUT(UPDATE_OUT),
	.CTRL_OUT(CTRL_OUT), .SEQ_EVT_IN(SEQ_EVT_IN), .ALERT_EVT_IN(ALERT_EVT_IN),
	.SEQ_IRQ_OUT(SEQ_IRQ_OUT), .ALERT_IRQ_OUT(ALERT_IRQ_OUT));
`default_nettype wire

//--- tb/qdc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module qdc_conv_model
	import qdc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic valid_in,
	input wire qdc_xfer_t xfer_in,
	input wire logic [7:0] lat_in,
	output logic done_out,
	output logic [STAT_W-1:0] status_out
);
	logic [7:0] cnt_q;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cnt_q <= 8'h0;
			done_out <= 1'b0;
			status_out <= 10'h000;
		end else if (valid_in && !done_out && cnt_q == lat_in) begin
			done_out <= 1'b1;
			status_out <= {xfer_in.sel, 7'h5a};
			cnt_q <= 8'h0;
		end else begin
			done_out <= 1'b0;
			// Fetched status is not held once the answer is gone
			status_out <= ~status_out;
			if (valid_in && !done_out) begin
				cnt_q <= cnt_q + 8'h1;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/tb_qdc_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_qdc_ctrl_regs
	import qdc_pkg::*;
;
	logic clk, rst_n, wr, rd, rvalid, xv, xdone, tick;
	logic [7:0] addr, lat, busy, chan, upd, sevt, aevt, sirq, airq, lirq;
	qdc_ctrl_t [N_CONV-1:0] ctl;
	logic [N_CONV-1:0][3:0][1:0] clr;
	logic [31:0] wdata, rdata;
	logic [STAT_W-1:0] xstat;
	qdc_xfer_t xfer;
	int error_cnt = 0;
	int compares = 0;
	qdc_ctrl_regs DUT (.CLOCK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WR_IN(wr),
		.REG_RD_IN(rd), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
		.XFER_OUT(xfer), .XFER_VALID_OUT(xv), .XFER_DONE_IN(xdone), .XFER_STATUS_IN(xstat),
		.BUSY_OUT(busy), .CHAN_DONE_IN(chan), .AUTO_TICK_IN(tick), .UPDATE_OUT(upd),
		.CTRL_OUT(ctl), .CLR_LVL_OUT(clr), .SEQ_EVT_IN(sevt), .ALERT_EVT_IN(aevt),
		.SEQ_IRQ_OUT(sirq), .ALERT_IRQ_OUT(airq), .LOAD_IRQ_OUT(lirq));
	qdc_conv_model u_conv (.clk_in(clk), .rst_n_in(rst_n), .valid_in(xv), .xfer_in(xfer),
		.lat_in(lat), .done_out(xdone), .status_out(xstat));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rvalid", 32'h1, {31'h0, rvalid});
		chk(n, e, rdata);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		repeat (3) @(posedge clk);
		#1;
		while ((xv || busy != 8'h0) && n < 500) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("idle", 32'h1, {31'h0, n < 500});
	endtask
	task automatic pulse_chan(input int i, input logic [7:0] e);
		@(posedge clk);
		chan <= 8'h1 << i;
		@(posedge clk);
		chan <= 8'h0;
		#1;
		chk("update", {24'h0, e}, {24'h0, upd});
	endtask
	task automatic t_reset;
		rd_chk("setup0", 8'h00, 32'h0000_4000);
		rd_chk("ctrl0", 8'h20, 32'h0);
		rd_chk("unmapped", 8'h80, 32'h0);
	endtask
	task automatic t_setup;
		lat <= 8'd15;
		wr_reg(8'h08, 32'hffff_ffff);
		rd_chk("setup2", 8'h08, 32'h000f_efff);
		chk("xfer_setup", 32'h00af_efff, {8'h0, xfer});
		wait_idle();
		rd_chk("stat2", 8'h48, {21'h0, 1'b1, 3'h2, 7'h5a});
		chk("clr2", 32'h55, {24'h0, clr[2]});
		wr_reg(8'h0c, 32'h1);
		wr_reg(8'h0c, 32'h2);
		wait_idle();
		rd_chk("setup3", 8'h0c, 32'h1);
		chk("clr3", 32'h0, {24'h0, clr[3]});
	endtask
	task automatic t_modes;
		wr_reg(8'h24, 32'hffff_ffff);
		rd_chk("ctrl_mask", 8'h24, 32'h0000_01bf);
		chk("ctrl_out1", 32'hff, {24'h0, ctl[1]});
		for (int c = 0; c < 8; c++) begin
			wr_reg(8'h30, 32'(c));
			pulse_chan(4, (c == 0 || c == 1 || c == 3) ? 8'h10 : 8'h0);
		end
	endtask
	task automatic t_stat_req;
		wr_reg(8'h14, 32'h0000_2303);
		wait_idle();
		chk("clr5", 32'h66, {24'h0, clr[5]});
		wr_reg(8'h34, 32'h201);
		rd_chk("stat5_req", 8'h54, {21'h0, 1'b0, 3'h5, 7'h5a});
		wait_idle();
		rd_chk("stat5_done", 8'h54, {21'h0, 1'b1, 3'h5, 7'h5a});
		wr_reg(8'h34, 32'h3);
		wr_reg(8'h34, 32'h203);
		rd_chk("stat5_timer", 8'h54, {21'h0, 1'b1, 3'h5, 7'h5a});
	endtask
	task automatic t_irq;
		wr_reg(8'h38, 32'h30);
		@(posedge clk);
		sevt <= 8'hc0;
		aevt <= 8'hc0;
		@(posedge clk);
		sevt <= 8'h0;
		aevt <= 8'h0;
		#1;
		chk("seq_irq", 32'h40, {24'h0, sirq});
		chk("alert_irq", 32'h40, {24'h0, airq});
	endtask
	task automatic t_global;
		wr_reg(8'h20, 32'h101);
		wr_reg(8'h24, 32'h109);
		pulse_chan(0, 8'h0);
		pulse_chan(1, 8'h03);
		chk("load_irq", 32'h02, {24'h0, lirq});
		chk("ctrl_out0", 32'h81, {24'h0, ctl[0]});
	endtask
	task automatic t_tick;
		wr_reg(8'h2c, 32'h80);
		@(posedge clk);
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("tick_xfer", 32'h13, {27'h0, xv, xfer.cfg, xfer.sel});
		wait_idle();
	endtask
	task automatic t_timer;
		int n;
		n = 0;
		wr_reg(8'h3c, 32'h83);
		pulse_chan(7, 8'h80);
		while (!xv && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("asr_delay", 32'h1, {31'h0, n >= 2499 && n <= 2505});
		chk("asr_xfer", 32'h7, {28'h0, xfer.cfg, xfer.sel});
	endtask
	task automatic conclude;
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		{rst_n, wr, rd, tick} = 4'h0;
		{addr, chan, sevt, aevt} = 32'h0;
		wdata = 32'h0;
		lat = 8'd2;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_setup();
		t_modes();
		t_stat_req();
		t_irq();
		t_global();
		t_tick();
		t_timer();
		conclude();
	end
	initial begin
		#200000;
		error_cnt++;
		conclude();
	end
endmodule
`default_nettype wire
